// File: logic/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // Status
  output logic              expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (tick && (count_r != '0)) begin
      count_nxt = count_r - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign expired = (count_r == '0);

endmodule

// File: logic/pfr_cfg.svh
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH

// System clock rate
`define PFR_CLK_HZ          200000000
// Internal oscillator rate
`define PFR_OSC_HZ          32768
// System clocks per oscillator tick, rounded to nearest
`define PFR_OSC_DIV         ((`PFR_CLK_HZ + (`PFR_OSC_HZ / 2)) / `PFR_OSC_HZ)

// Power-up recovery delay, typical and longest, in ms
`define PFR_REC_MS          250
`define PFR_REC_MAX_MS      300
// Pushbutton debounce time in ms
`define PFR_DEBOUNCE_MS     250
// Reset active time after a press in ms
`define PFR_ACTIVE_MS       250

// Oscillator ticks for each interval
`define PFR_REC_TICKS       ((`PFR_REC_MS * `PFR_OSC_HZ) / 1000)
`define PFR_DEBOUNCE_TICKS  ((`PFR_DEBOUNCE_MS * `PFR_OSC_HZ) / 1000)
`define PFR_ACTIVE_TICKS    ((`PFR_ACTIVE_MS * `PFR_OSC_HZ) / 1000)

// Counter width for all timers
`define PFR_CNT_W           16

// Reset value of the pin drive (driving low)
`define PFR_DRIVE_RST       1'b1

`endif

// File: logic/pfr_pkg.sv
package pfr_pkg;

  typedef enum logic [2:0] {
    ST_PWR_FAIL,
    ST_RECOVERY,
    ST_IDLE,
    ST_DEBOUNCE,
    ST_PB_ACTIVE,
    ST_PB_RELEASE
  } reset_state_e;

  typedef struct packed {
    logic out_val;
    logic oe;
  } pin_drive_s;

endpackage

// File: logic/power_fail_pushbutton_reset.sv
// Functional notes
// - Drive reset pin low while supply is below the power-fail threshold.
// - After supply returns, hold pin low for recovery delay, then release it.
// - oscillator_disable_n high: skip recovery delay and release the pin at once.
// - Pin level gates nothing else; tick divider and interval counter unaffected.
// - Pin is also an input; debounce a pushbutton low and then drive reset.
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module power_fail_pushbutton_reset
  import pfr_pkg::*;
#(
  parameter int OSC_DIV        = `PFR_OSC_DIV,
  parameter int REC_TICKS      = `PFR_REC_TICKS,
  parameter int DEBOUNCE_TICKS = `PFR_DEBOUNCE_TICKS,
  parameter int ACTIVE_TICKS   = `PFR_ACTIVE_TICKS,
  parameter int CNT_W          = `PFR_CNT_W
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Supply monitor and oscillator control
  input  wire logic  power_fail,
  input  wire logic  oscillator_disable_n,
  // Reset pin, open drain, active low
  input  wire logic  rst_pin_n_in,
  output pin_drive_s rst_pin_n_drv,
  // Status
  output logic       osc_tick,
  output logic       press_seen
);

  reset_state_e     state_r;
  reset_state_e     state_nxt;
  logic             drive_r;
  logic             drive_nxt;
  logic             press_r;
  logic             press_nxt;
  logic             load;
  logic [CNT_W-1:0] load_val;
  logic             expired;
  logic             div_expired;

  // Oscillator tick divider
  interval_timer #(.W(CNT_W)) u_div (
    .clk      (clk),
    .rst      (rst),
    .load     (div_expired),
    .load_val (CNT_W'(OSC_DIV - 1)),
    .tick     (1'b1),
    .expired  (div_expired)
  );

  assign osc_tick = div_expired;

  // Interval counter on oscillator ticks
  interval_timer #(.W(CNT_W)) u_interval (
    .clk      (clk),
    .rst      (rst),
    .load     (load),
    .load_val (load_val),
    .tick     (osc_tick),
    .expired  (expired)
  );

  always_comb begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = '0;
    press_nxt = 1'b0;
    if (power_fail) begin
      state_nxt = ST_PWR_FAIL;
    end else begin
      unique case (state_r)
        ST_PWR_FAIL: begin
          if (oscillator_disable_n) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_RECOVERY;
            load      = 1'b1;
            load_val  = CNT_W'(REC_TICKS);
          end
        end
        ST_RECOVERY: begin
          if (oscillator_disable_n || expired) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!rst_pin_n_in) begin
            state_nxt = ST_DEBOUNCE;
            load      = 1'b1;
            load_val  = CNT_W'(DEBOUNCE_TICKS);
          end
        end
        ST_DEBOUNCE: begin
          if (rst_pin_n_in) begin
            state_nxt = ST_IDLE;
          end else if (expired) begin
            state_nxt = ST_PB_ACTIVE;
            press_nxt = 1'b1;
            load      = 1'b1;
            load_val  = CNT_W'(ACTIVE_TICKS);
          end
        end
        ST_PB_ACTIVE: begin
          if (expired) begin
            state_nxt = ST_PB_RELEASE;
          end
        end
        ST_PB_RELEASE: begin
          if (rst_pin_n_in) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_PWR_FAIL;
        end
      endcase
    end
    // Pin drive follows the state only; nothing else sees it
    drive_nxt = (state_nxt == ST_PWR_FAIL) || (state_nxt == ST_RECOVERY)
                || (state_nxt == ST_PB_ACTIVE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_PWR_FAIL;
      drive_r <= `PFR_DRIVE_RST;
      press_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      drive_r <= drive_nxt;
      press_r <= press_nxt;
    end
  end

  assign rst_pin_n_drv.out_val = 1'b0;
  assign rst_pin_n_drv.oe      = drive_r;
  assign press_seen            = press_r;

endmodule

// File: verif/pfr_properties.sv
`timescale 1ns/1ps
module pfr_properties
  import pfr_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       power_fail,
  input wire logic       oscillator_disable_n,
  input wire logic       rst_pin_n_in,
  input wire pin_drive_s rst_pin_n_drv,
  input wire logic       osc_tick,
  input wire logic       press_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_fail; power_fail |=> rst_pin_n_drv.oe; endproperty
  a_fail: assert property (p_fail) else $error("pin not driven");
  property p_od; !rst_pin_n_drv.out_val; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_rec; $fell(power_fail) && !oscillator_disable_n |=> rst_pin_n_drv.oe[*8]; endproperty
  a_rec: assert property (p_rec) else $error("recovery cut short");
  property p_byp;
    $fell(power_fail) && oscillator_disable_n ##1 oscillator_disable_n && !power_fail |=> !rst_pin_n_drv.oe;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass late");
  property p_tick; osc_tick |-> ##4 osc_tick; endproperty
  a_tick: assert property (p_tick) else $error("divider disturbed");
  property p_deb; press_seen |-> rst_pin_n_drv.oe && !$past(rst_pin_n_in) && !$past(rst_pin_n_in, 8); endproperty
  a_deb: assert property (p_deb) else $error("press not debounced");
  property p_act; press_seen |=> rst_pin_n_drv.oe[*8]; endproperty
  a_act: assert property (p_act) else $error("press hold short");
  c_press: cover property (press_seen);
  c_rec: cover property ($fell(power_fail) && !oscillator_disable_n);
  c_byp: cover property ($fell(power_fail) && oscillator_disable_n);
endmodule
bind power_fail_pushbutton_reset pfr_properties pfr_properties_inst (.*);

// File: verif/pushbutton_model.sv
`timescale 1ns/1ps
module pushbutton_model
  import pfr_pkg::*;
(
  // Button and device drive
  input wire logic       press,
  input wire pin_drive_s drv,
  // Resolved pin
  output logic           pin_n
);
  // Pullup unless device or button pulls low
  assign pin_n = (drv.oe || press) ? 1'b0 : 1'b1;
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int DIV = 4, REC = 5, DEB = 3, ACT = 4;
  logic                clk, rst, pf, dis, btn, pin_n, tick, seen;
  pfr_pkg::pin_drive_s drv;
  int                  fail_count = 0, cmp_count = 0, n;
  power_fail_pushbutton_reset #(.OSC_DIV(DIV), .REC_TICKS(REC), .DEBOUNCE_TICKS(DEB), .ACTIVE_TICKS(ACT))
    power_fail_pushbutton_reset_inst (.clk(clk), .rst(rst), .power_fail(pf), .oscillator_disable_n(dis),
    .rst_pin_n_in(pin_n), .rst_pin_n_drv(drv), .osc_tick(tick), .press_seen(seen));
  pushbutton_model pushbutton_model_inst (.press(btn), .drv(drv), .pin_n(pin_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_oe(input logic v);
    n = 0;
    while (drv.oe !== v && n < 200) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic test_recovery;
    pf = 1'b1;
    cyc(2);
    chk(pin_n, 1'b0);
    n = 0;
    repeat (DIV * 4) begin
      cyc(1);
      if (tick === 1'b1) n++;
    end
    chk(n == 4, 1'b1);
    pf = 1'b0;
    wait_oe(1'b0);
    chk(n >= (REC - 1) * DIV && n <= REC * DIV + 2, 1'b1);
    chk(pin_n, 1'b1);
    $display("test_recovery done");
  endtask
  task automatic test_bypass;
    pf = 1'b1;
    dis = 1'b1;
    cyc(2);
    chk(drv.oe, 1'b1);
    pf = 1'b0;
    cyc(1);
    chk(drv.oe, 1'b0);
    cyc(1);
    chk(drv.oe, 1'b0);
    dis = 1'b0;
    $display("test_bypass done");
  endtask
  task automatic test_bounce;
    btn = 1'b1;
    cyc(DIV);
    btn = 1'b0;
    cyc(DIV * DEB * 3);
    chk(drv.oe, 1'b0);
    $display("test_bounce done");
  endtask
  task automatic test_press;
    btn = 1'b1;
    n = 0;
    while (seen !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n >= (DEB - 1) * DIV && n < 100, 1'b1);
    chk(drv.oe, 1'b1);
    btn = 1'b0;
    wait_oe(1'b0);
    chk(n >= (ACT - 1) * DIV && n <= ACT * DIV + 1, 1'b1);
    $display("test_press done");
  endtask
  initial begin
    #30000;
    fail_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    pf = 1'b1;
    dis = 1'b0;
    btn = 1'b0;
    cyc(5);
    rst = 1'b0;
    test_recovery();
    test_bypass();
    test_bounce();
    test_press();
    end_of_test();
  end
endmodule
